// ---- hw/flash_op_timer.sv ----
// Programming-time counter for one timed flash operation: page erase, page write or lock-bit write.
`timescale 1ns/1ps
`default_nettype none
module flash_op_timer #(
  parameter int unsigned OP_CYCLES = selfprog_pkg::OP_MIN_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Sequencer side
  op_timer_if.tmr tif
);
  import selfprog_pkg::*;

  logic [CNT_W-1:0] cnt_ff;
  logic busy_ff;
  logic last;

  assign last = busy_ff && (cnt_ff == CNT_W'(OP_CYCLES - 1));
  assign tif.busy = busy_ff;
  assign tif.done = last;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
    end else if (tif.start && !busy_ff) begin
      busy_ff <= 1'b1;
    end else if (last) begin
      busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
    end else if (!busy_ff) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  done_count_a: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(busy_ff) |-> $past(cnt_ff) == CNT_W'(OP_CYCLES - 1))
    else $error("operation timer ended early");
  max_time_a: assert property (@(posedge core_clk) disable iff (!rstn)
    busy_ff |-> (cnt_ff < CNT_W'(OP_MAX_CYC)))
    else $error("operation timer ran past its longest time");

endmodule : flash_op_timer
`default_nettype wire

// ---- hw/flash_selfprog.sv ----
// Self-programming sequencer: control register, page buffer, boot decode and read-while-write guard.
`timescale 1ns/1ps
`default_nettype none
module flash_selfprog #(
  parameter int unsigned OP_CYCLES = selfprog_pkg::OP_MIN_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Register port
  input wire logic [selfprog_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // CPU store instruction
  input wire logic spm_exec,
  input wire logic [15:0] z_ptr,
  input wire logic [15:0] spm_data,
  input wire logic eeprom_write_busy_bit,
  // Fetch guard
  input wire logic [11:0] fetch_addr,
  output logic fetch_hold,
  // Fuse pins
  input wire logic boot_size_fuse_hi,
  input wire logic boot_size_fuse_lo,
  output logic [11:0] boot_reset_addr,
  output logic [11:0] app_end_addr,
  // Flash array
  output logic flash_erase_req,
  output logic flash_write_req,
  output logic flash_lock_req,
  output logic [selfprog_pkg::PAGE_W-1:0] flash_page,
  input wire logic [selfprog_pkg::WORD_W-1:0] buf_rd_idx,
  output logic [15:0] buf_rd_data
);
  import selfprog_pkg::*;

  op_timer_if tif ();
  flash_op_timer #(.OP_CYCLES(OP_CYCLES)) u_timer (
    .core_clk(core_clk),
    .rstn(rstn),
    .tif(tif)
  );

  logic en_ff, erase_ff, write_ff, lock_ff, reen_ff;
  logic region_busy_ff, page_op_ff;
  logic [2:0] window_ff;
  logic [3:0] lock_bits_ff;
  logic [1:0] fuse_s1_ff, fuse_s2_ff;
  logic [15:0] buf_mem [PAGE_WORDS];
  logic [7:0] reg_rdata_ff;
  logic [15:0] buf_rd_ff;
  logic [PAGE_W-1:0] page_ff;
  logic erase_req_ff, write_req_ff, lock_req_ff;
  logic ctrl_wr, ctrl_ok, spm_ok, fill, timed, win_end;
  logic [WORD_W-1:0] zword;

  //////////////////////////////////////////////////////////////////////////////
  // Command acceptance

  // An EEPROM write or a running command locks the control register against new commands.
  assign ctrl_wr = reg_wr && (reg_addr == CTRL_OFS);
  assign ctrl_ok = ctrl_wr && !eeprom_write_busy_bit && !en_ff;
  assign spm_ok = spm_exec && (window_ff != 3'h0);
  assign timed = erase_ff || write_ff || lock_ff;
  assign fill = spm_ok && !timed && !reen_ff;
  assign win_end = (window_ff == 3'h1) && !spm_exec;
  assign zword = z_ptr[ZWORD_LSB +: WORD_W];
  assign tif.start = spm_ok && timed && !tif.busy;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      window_ff <= 3'h0;
    end else if (ctrl_ok && reg_wdata[EN_BIT]) begin
      window_ff <= WIN_CYC;
    end else if (spm_exec || window_ff == 3'h0) begin
      window_ff <= 3'h0;
    end else begin
      window_ff <= window_ff - 3'h1;
    end
  end

  // Command bits stay up through a timed operation so polling software sees it running.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {reen_ff, lock_ff, write_ff, erase_ff, en_ff} <= CTRL_RST[4:0];
    end else if (ctrl_ok) begin
      en_ff <= reg_wdata[EN_BIT];
      erase_ff <= reg_wdata[ERASE_BIT] && reg_wdata[EN_BIT];
      write_ff <= reg_wdata[WRITE_BIT] && reg_wdata[EN_BIT];
      lock_ff <= reg_wdata[LOCK_BIT] && reg_wdata[EN_BIT];
      reen_ff <= reg_wdata[REEN_BIT] && reg_wdata[EN_BIT];
    end else if (tif.done || win_end || (spm_ok && !timed)) begin
      {reen_ff, lock_ff, write_ff, erase_ff, en_ff} <= CTRL_RST[4:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Region busy and fetch guard

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      page_op_ff <= 1'b0;
    end else if (tif.start) begin
      page_op_ff <= erase_ff || write_ff;
    end else if (tif.done) begin
      page_op_ff <= 1'b0;
    end
  end

  // Setting wins over the re-enable, and re-enable is refused while a page operation runs.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      region_busy_ff <= 1'b0;
    end else if (tif.start && (erase_ff || write_ff)) begin
      region_busy_ff <= 1'b1;
    end else if (spm_ok && reen_ff && !page_op_ff) begin
      region_busy_ff <= 1'b0;
    end
  end

  assign fetch_hold = page_op_ff && (fetch_addr <= RWW_LAST);

  //////////////////////////////////////////////////////////////////////////////
  // Page buffer and flash requests

  always_ff @(posedge core_clk) begin
    if (fill) begin
      buf_mem[zword] <= spm_data;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      buf_rd_ff <= 16'h0000;
    end else begin
      buf_rd_ff <= buf_mem[buf_rd_idx];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      page_ff <= '0;
      erase_req_ff <= 1'b0;
      write_req_ff <= 1'b0;
      lock_req_ff <= 1'b0;
    end else begin
      if (tif.start) begin
        page_ff <= z_ptr[ZPAGE_LSB +: PAGE_W];
      end
      erase_req_ff <= tif.start && erase_ff;
      write_req_ff <= tif.start && write_ff && !erase_ff;
      lock_req_ff <= tif.start && lock_ff && !erase_ff && !write_ff;
    end
  end

  // Programmed lock bits read as zero and can only be cleared here; only reset sets them back.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lock_bits_ff <= LOCK_RST;
    end else if (tif.start && lock_ff && !erase_ff && !write_ff) begin
      lock_bits_ff <= lock_bits_ff & spm_data[5:2];
    end
  end

  assign flash_erase_req = erase_req_ff;
  assign flash_write_req = write_req_ff;
  assign flash_lock_req = lock_req_ff;
  assign flash_page = page_ff;
  assign buf_rd_data = buf_rd_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Boot fuses and register reads

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fuse_s1_ff <= 2'h0;
      fuse_s2_ff <= 2'h0;
    end else begin
      fuse_s1_ff <= {boot_size_fuse_hi, boot_size_fuse_lo};
      fuse_s2_ff <= fuse_s1_ff;
    end
  end

  assign boot_reset_addr = boot_start(fuse_s2_ff);
  assign app_end_addr = boot_start(fuse_s2_ff) - 12'h001;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_ff <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata_ff <= 8'h00;
    end else begin
      case (reg_addr)
        CTRL_OFS: reg_rdata_ff <= {1'b0, region_busy_ff, 1'b0, reen_ff, lock_ff, write_ff, erase_ff, en_ff};
        BOOT_OFS: reg_rdata_ff <= {6'h00, fuse_s2_ff};
        LOCK_OFS: reg_rdata_ff <= {2'h3, lock_bits_ff, 2'h3};
        default: reg_rdata_ff <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = reg_rdata_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  win_expire_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (ctrl_ok && reg_wdata[EN_BIT]) ##1 (!spm_exec)[*4] |=> !en_ff && !flash_erase_req)
    else $error("store accepted outside the four-cycle window");
  ee_block_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (ctrl_wr && eeprom_write_busy_bit && !en_ff) |=> !en_ff)
    else $error("control write taken during EEPROM write");
  enable_clear_a: assert property (@(posedge core_clk) disable iff (!rstn)
    tif.done |=> !en_ff && !tif.busy)
    else $error("enable bit not cleared at operation end");
  region_busy_a: assert property (@(posedge core_clk) disable iff (!rstn)
    page_op_ff |-> region_busy_ff)
    else $error("region busy flag low during page operation");
  rww_block_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (page_op_ff && fetch_addr < BOOT_1024) |-> fetch_hold)
    else $error("readable region fetch not held during page operation");
  stalled_write_region_open_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (fetch_addr >= BOOT_1024) |-> !fetch_hold)
    else $error("stalled region fetch was held");
  erase_page_a: assert property (@(posedge core_clk) disable iff (!rstn)
    (tif.start && erase_ff) |=> flash_erase_req && flash_page == $past(z_ptr[12:6]) ##1 !flash_erase_req)
    else $error("erase request or page address wrong");
  buf_fill_a: assert property (@(posedge core_clk) disable iff (!rstn)
    fill |=> buf_mem[$past(z_ptr[5:1])] == $past(spm_data))
    else $error("page buffer word not filled from Z5:Z1");
  boot_decode_a: assert property (@(posedge core_clk) disable iff (!rstn)
    boot_reset_addr == (12'h000 - (12'h080 << (2'h3 - fuse_s2_ff))) && app_end_addr == boot_reset_addr - 12'h001)
    else $error("boot section decode wrong");

endmodule : flash_selfprog
`default_nettype wire

// ---- hw/op_timer_if.sv ----
// Start and completion signals between the sequencer and its programming timer.
`timescale 1ns/1ps
`default_nettype none
interface op_timer_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface : op_timer_if
`default_nettype wire

// ---- hw/selfprog_pkg.sv ----
// Constants, register layout and Z pointer mapping for the flash self-programming block.
// Behaviour
// - Each erase, page write or lock-bit write lasts between 3.7 ms and 4.5 ms.
// - Boot-size fuses give boot section 128/256/512/1024 words from 0xF80/0xF00/0xE00/0xC00.
// - Words 0x000-0xBFF form the readable region, 0xC00-0xFFF the stalled region.
// - During page erase or write only stalled-region fetches are allowed.
// - Page holds 32 words; Z5:Z1 select the buffer word when filling.
// - Page for erase or write comes from Z12:Z6, i.e. PC[11:5].
// - Z15:Z13 are ignored; Z0 should be zero for self-programming commands.
// - Program counter is 12 bits, mapped one position higher in Z.
// - Region-busy flag stays set until software writes re-enable plus enable and then issues a store within the window.
// - A store takes effect only within four cycles after the control write.
// - Reads of the readable region are always blocked during erase or write.
`default_nettype none
package selfprog_pkg;

  // Register port map.
  localparam int ADDR_W = 2;
  localparam logic [1:0] CTRL_OFS = 2'h0;
  localparam logic [1:0] BOOT_OFS = 2'h1;
  localparam logic [1:0] LOCK_OFS = 2'h2;

  // Control register fields.
  localparam int EN_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int WRITE_BIT = 2;
  localparam int LOCK_BIT = 3;
  localparam int REEN_BIT = 4;
  localparam int BUSY_BIT = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] LOCK_RST = 4'hF;

  // Address geometry.
  localparam int PC_W = 12;
  localparam int PAGE_WORDS = 32;
  localparam int WORD_W = 5;
  localparam int PAGE_W = 7;
  localparam int ZWORD_LSB = 1;
  localparam int ZPAGE_LSB = 6;
  localparam logic [11:0] RWW_LAST = 12'hBFF;
  localparam logic [11:0] BOOT_128 = 12'hF80;
  localparam logic [11:0] BOOT_256 = 12'hF00;
  localparam logic [11:0] BOOT_512 = 12'hE00;
  localparam logic [11:0] BOOT_1024 = 12'hC00;

  // Timing.
  localparam logic [2:0] WIN_CYC = 3'h4;
  localparam int CLK_MHZ = 250;
  localparam int OP_MIN_NS = 3700000;
  localparam int OP_MAX_NS = 4500000;
  localparam int OP_MIN_CYC = (OP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int OP_MAX_CYC = (OP_MAX_NS * CLK_MHZ) / 1000;
  localparam int CNT_W = 21;

  function automatic logic [11:0] boot_start(input logic [1:0] fuse);
    case (fuse)
      2'b11: boot_start = BOOT_128;
      2'b10: boot_start = BOOT_256;
      2'b01: boot_start = BOOT_512;
      default: boot_start = BOOT_1024;
    endcase
  endfunction : boot_start

endpackage : selfprog_pkg
`default_nettype wire

// ---- sim/cpu_model.sv ----
// CPU-side model: register accesses and timed store instructions towards the self-programming block.
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [selfprog_pkg::ADDR_W-1:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Store instruction
  output logic spm_exec,
  output logic [15:0] z_ptr,
  output logic [15:0] spm_data,
  input wire logic ee_busy
);
  import selfprog_pkg::*;

  // Counts EEPROM waits that ran out; the bench adds these to its mismatches.
  int stalls = 0;

  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, spm_exec, z_ptr, spm_data} = '0;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : rd

  task automatic poll(output logic ok);
    logic [7:0] d;
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      rd(CTRL_OFS, d);
      ok = !d[EN_BIT];
    end
  endtask : poll

  // The store follows the control write after k cycles; k of 0 sends no store.
  task automatic cmd(input logic [7:0] c, input logic [15:0] z, input logic [15:0] dat, input int k);
    for (int i = 0; i < 50 && ee_busy; i++) begin
      @(posedge core_clk);
    end
    if (ee_busy) begin
      stalls++;
    end
    z_ptr <= {z[15:1], 1'b0};
    spm_data <= dat;
    wr(CTRL_OFS, c);
    if (k > 0) begin
      repeat (k - 1) @(posedge core_clk);
      spm_exec <= 1'b1;
      @(posedge core_clk);
      spm_exec <= 1'b0;
    end
  endtask : cmd
endmodule : cpu_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the self-programming block against a behavioural reference.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import selfprog_pkg::*;
  localparam int OPC = 20;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d, c;
  logic reg_wr, reg_rd, spm_exec, fetch_hold, ok;
  logic ee = 1'b0;
  logic fz_hi = 1'b0;
  logic fz_lo = 1'b0;
  logic [15:0] z_ptr, spm_data, buf_rd_data;
  logic [11:0] fetch_addr = 12'h000;
  logic [11:0] boot_reset_addr, app_end_addr;
  wire [2:0] req;
  logic [PAGE_W-1:0] flash_page;
  logic [WORD_W-1:0] buf_rd_idx = '0;
  logic [WORD_W-1:0] idx_q [$];
  logic [31:0] w;
  int errors, cmp_count, cyc, t_req, el;
  int seed = 64656;
  int lock_m = 32'h0000000F;
  int mem_m [32];
  int n_m [3];
  int n_req [3];

  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cyc++;
    for (int i = 0; i < 3; i++) begin
      if (req[i] === 1'b1) begin
        n_req[i]++;
        t_req = cyc;
      end
    end
  end

  flash_selfprog #(.OP_CYCLES(OPC)) dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spm_exec(spm_exec),
    .z_ptr(z_ptr), .spm_data(spm_data), .eeprom_write_busy_bit(ee), .fetch_addr(fetch_addr),
    .fetch_hold(fetch_hold), .boot_size_fuse_hi(fz_hi), .boot_size_fuse_lo(fz_lo),
    .boot_reset_addr(boot_reset_addr), .app_end_addr(app_end_addr), .flash_erase_req(req[0]),
    .flash_write_req(req[1]), .flash_lock_req(req[2]), .flash_page(flash_page), .buf_rd_idx(buf_rd_idx),
    .buf_rd_data(buf_rd_data));

  cpu_model cpu (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spm_exec(spm_exec), .z_ptr(z_ptr), .spm_data(spm_data),
    .ee_busy(ee));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    errors = errors + cpu.stalls;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // A poll that never sees the enable drop means a hung operation, so the run stops there.
  task automatic idle;
    cpu.poll(ok);
    if (ok !== 1'b1) begin
      errors++;
      close_out();
    end
  endtask : idle

  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    check(OP_MIN_CYC * 4 >= 3700000 && OP_MAX_CYC * 4 <= 4500000, 1);
    for (int f = 3; f >= 0; f--) begin
      {fz_hi, fz_lo} <= f[1:0];
      repeat (4) @(posedge core_clk);
      w[11:0] = 12'h000 - (12'h080 << (3 - f));
      check(boot_reset_addr, w[11:0]);
      check(app_end_addr, w[11:0] - 12'h001);
      cpu.rd(BOOT_OFS, d);
      check(d, f);
    end
    $display("fuse decode test done");
    for (int i = 0; i < 6; i++) begin
      w = $random(seed);
      cpu.cmd(8'h01, w[15:0], w[31:16], 1 + i % 4);
      mem_m[w[5:1]] = w[31:16];
      idx_q.push_back(w[5:1]);
      idle();
    end
    foreach (idx_q[i]) begin
      buf_rd_idx <= idx_q[i];
      repeat (2) @(posedge core_clk);
      check(buf_rd_data, mem_m[idx_q[i]]);
    end
    $display("buffer fill test done");
    for (int op = 0; op < 3; op++) begin
      w = $random(seed);
      c = (8'h02 << op) | 8'h01;
      cpu.cmd(c, {w[15:6], 6'h00}, w[31:16], 4);
      n_m[op]++;
      fetch_addr <= 12'hBFF;
      @(posedge core_clk);
      check(fetch_hold, op < 2);
      fetch_addr <= 12'hC00;
      @(posedge core_clk);
      check(fetch_hold, 0);
      fetch_addr <= 12'hBFF;
      if (op < 2) check(flash_page, w[12:6]);
      cpu.rd(CTRL_OFS, d);
      check(d[BUSY_BIT], op < 2);
      idle();
      el = cyc - t_req;
      check(el >= OPC && el <= OPC + 8, 1);
      check(n_req[op], n_m[op]);
      check(fetch_hold, 0);
      if (op == 2) lock_m = lock_m & w[21:18];
      cpu.rd(LOCK_OFS, d);
      check(d, {2'b11, lock_m[3:0], 2'b11});
      if (op < 2) begin
        cpu.rd(CTRL_OFS, d);
        check(d[BUSY_BIT], 1);
        cpu.cmd(8'h11, 16'h0000, 16'h0000, 2);
        idle();
        cpu.rd(CTRL_OFS, d);
        check(d, 8'h00);
      end
      $display("flash operation %0d test done", op);
    end
    for (int k = 0; k < 6; k += 5) begin
      cpu.cmd(8'h03, 16'h0000, 16'h0000, k);
      repeat (6) @(posedge core_clk);
      cpu.rd(CTRL_OFS, d);
      check(d, 8'h00);
      check(n_req[0], n_m[0]);
    end
    $display("store window test done");
    ee <= 1'b1;
    cpu.wr(CTRL_OFS, 8'h03);
    ee <= 1'b0;
    cpu.rd(CTRL_OFS, d);
    check(d, 8'h00);
    $display("eeprom busy test done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
